//--- common/sgr_pkg.sv
/*
 * Shared constants and types of the strain result readout block.
 * Assumes a 100 MHz mclk and a host that reads the words over a serial link.
 */
package sgr_pkg;
    // Word addresses of the read side.
    localparam logic [2:0] ADDR_HB1 = 3'h0;
    localparam logic [2:0] ADDR_HB2 = 3'h1;
    localparam logic [2:0] ADDR_STAT = 3'h2;
    localparam logic [2:0] ADDR_CFG0 = 3'h3;
    localparam logic [2:0] ADDR_DISCHARGE_TIME_WORD = 3'h4;
    localparam logic [2:0] ADDR_CALIBRATION_PERIOD_WORD = 3'h5;
    localparam logic [2:0] ADDR_RD1 = 3'h6;
    localparam logic [2:0] ADDR_RD2 = 3'h7;
    // Status word bit positions.
    localparam int ST_ACTIVE_BIT = 23;
    localparam int ST_TMP_VALID_BIT = 22;
    localparam int ST_HB2_VALID_BIT = 21;
    localparam int ST_HB1_VALID_BIT = 20;
    localparam int ST_ERR_BIT = 19;
    localparam int ST_TO_TMP_BIT = 18;
    localparam int ST_TO_HB2_BIT = 17;
    localparam int ST_TO_HB1_BIT = 16;
    // Fixed-point layouts.
    localparam int HB_FRAC_BITS = 8;
    localparam int TDC_FRAC_BITS = 16;
    localparam int CAL_STEP_SHIFT = 3;
    // Reset value of every word.
    localparam logic [23:0] WORD_RST = 24'h000000;
    // Discharge and charge cycles per halfbridge measurement.
    localparam logic [2:0] LAST_CYCLE = 3'h7;
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHARGE_TIME_NS = 500;
    localparam int CHARGE_CYC = (CHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_PERIOD_NS;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHARGE = 4'h2,
        ST_DISCH = 4'h4,
        ST_DONE = 4'h8
    } sgr_state_e;

    // Static mode options from the write side.
    typedef struct packed {
        logic dblBridge;
        logic sumOpt;
        logic diffOpt;
        logic range1;
        logic [1:0] divExp;
        logic [23:0] cfgWord;
    } sgr_cfg_s;

    // Whole register state of the readout module.
    typedef struct packed {
        sgr_state_e st;
        logic [15:0] cnt;
        logic [2:0] cyc;
        logic half;
        logic lastHalf;
        logic res;
        logic fb;
        logic alt;
        logic [19:0] accA;
        logic [19:0] accB;
        logic [1:0][23:0] halfVal;
        logic [1:0] tmo;
        logic [1:0] measured;
        logic [23:0] hb1;
        logic [23:0] hb2;
        logic [23:0] discharge_time_word;
        logic [23:0] calibration_period_word;
        logic [23:0] rd1;
        logic [23:0] rd2;
        logic [15:0] tempRes;
        logic vTmp;
        logic vHb1;
        logic vHb2;
        logic errDsp;
        logic toHb1;
        logic toHb2;
        logic toTmp;
        logic [23:0] rdData;
        logic rdValid;
    } sgr_regs_s;
endpackage : sgr_pkg

//--- verif/sgr_cmp_model.sv
/* Behavioural comparator at the far side of the discharge pins.
   Assumes dischSel holds steady through each discharge. */
`timescale 1ns/100ps
`default_nettype none
module sgr_cmp_model (
    input wire logic mclk,
    input wire logic dischEn,
    input wire logic [2:0] dischSel,
    input wire logic stuck,
    output logic cmpTrig
);
    logic [7:0] elapsed = 8'h00; // Cycles since the discharge began.
    logic [7:0] delay; // Discharge time of the selected resistor.
    // Resistor zero's time grows with half and bridge; resistor one's is fixed at 2 cycles, so results tell them apart.
    assign delay = 8'h02 + (dischSel[0] ? 8'h00 : 8'h01 + {7'h00, dischSel[1]}
        + {6'h00, dischSel[2], 1'h0});
    always_ff @(posedge mclk) begin
        elapsed <= dischEn ? elapsed + 8'h01 : 8'h00;
    end
    // Low while charged; a stuck comparator never trips, forcing the time-out path.
    assign cmpTrig = dischEn && !stuck && elapsed >= delay;
endmodule : sgr_cmp_model
`default_nettype wire

//--- verif/sgr_readout_asserts.sv
/* Checker of the result readout, bound into sgr_readout.
   Assumes sgr_pkg is compiled first. */
`timescale 1ns/100ps
`default_nettype none
module sgr_readout_asserts
    import sgr_pkg::*;
#(
    parameter int TimeoutCyc = TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sgr_cfg_s cfg,
    input wire logic cmpTrig,
    input wire logic tdcMemReq,
    input wire logic aluMemReq,
    input wire logic rdEn,
    input wire logic [2:0] rdAddr,
    input wire logic [23:0] rdData,
    input wire logic rdValid,
    input wire logic chargeEn,
    input wire logic dischEn,
    input wire logic [2:0] dischSel,
    input wire logic busy
);
    logic [15:0] chgCnt; // Cycles of the current charge.
    logic [7:0] dCnt; // Discharges of this measurement.
    logic lastRes; // Resistor of the previous discharge.
    logic dPrev; // Discharge enable one cycle back.
    // Counters stand in for repetitions too long to unroll.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chgCnt <= 16'h0000;
            dCnt <= 8'h00;
            lastRes <= 1'h1;
            dPrev <= 1'h0;
        end else begin
            chgCnt <= chargeEn ? chgCnt + 16'h0001 : 16'h0000;
            dCnt <= busy ? dCnt + {7'h00, dischEn && !dPrev} : 8'h00;
            lastRes <= dischEn ? dischSel[0] : lastRes;
            dPrev <= dischEn;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (rdValid == $past(rdEn))
        else $error("read answer out of step");
    a_cfg_mirror: assert property (rdEn && rdAddr == ADDR_CFG0 |=> rdData == $past(cfg.cfgWord))
        else $error("mirror word wrong");
    a_charge_len: assert property ($fell(chargeEn) |-> chgCnt == CHARGE_CYC)
        else $error("charge length wrong");
    a_no_overlap: assert property (!(chargeEn && dischEn))
        else $error("charge and discharge overlap");
    a_trig_ends: assert property (dischEn && cmpTrig |=> !dischEn)
        else $error("discharge outlived trigger");
    a_res_toggle: assert property ($rose(dischEn) |-> dischSel[0] != lastRes)
        else $error("resistor did not alternate");
    a_eight_cycles: assert property ($fell(busy) |-> dCnt[2:0] == 3'h0 && dCnt != 8'h00)
        else $error("discharges not a multiple of eight");
    a_err_flag: assert property (tdcMemReq && aluMemReq ##[1:3]
        rdEn && rdAddr == ADDR_STAT |=> rdData[ST_ERR_BIT])
        else $error("collision flag missing");
endmodule : sgr_readout_asserts
bind sgr_readout sgr_readout_asserts #(.TimeoutCyc(TimeoutCyc)) u_chk (.mclk(mclk),
    .rst_n(rst_n), .cfg(cfg), .cmpTrig(cmpTrig), .tdcMemReq(tdcMemReq), .aluMemReq(aluMemReq),
    .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid), .chargeEn(chargeEn),
    .dischEn(dischEn), .dischSel(dischSel), .busy(busy));
`default_nettype wire

//--- verif/tb_strain_result_readout.sv
/* Bench of the strain result readout.
   Assumes the package, the readout, its checker and sgr_cmp_model. */
`timescale 1ns/100ps
`default_nettype none
module tb_strain_result_readout;
    import sgr_pkg::*;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    sgr_cfg_s cfg = '0; // Mode levels, changed only while idle.
    logic measStart = 1'h0, tempDone = 1'h0, tempTimeout = 1'h0, calDone = 1'h0, rdsonDone = 1'h0;
    logic tdcMemReq = 1'h0, aluMemReq = 1'h0, rdEn = 1'h0, stuck = 1'h0;
    logic rdValid, chargeEn, dischEn, busy, cmpTrig;
    logic [15:0] tempValue = 16'h1234;
    logic [23:0] calRaw = 24'hABCDE8, rdsonOne = 24'h13579B, rdsonTwo = 24'h2468AC, rdData;
    logic [2:0] rdAddr = 3'h0, dischSel;
    int miscompares = 0, nChecks = 0;
    // Adjust values that the host keeps in its write image; the readout never sees them.
    localparam logic [5:0] HostCoreAdjust = 6'h11;
    localparam logic [6:0] HostCalAdjust = 7'h3F;
    always #5 mclk = ~mclk;
    sgr_readout #(.TimeoutCyc(20)) uut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg),
        .measStart(measStart), .cmpTrig(cmpTrig), .tempDone(tempDone), .tempValue(tempValue),
        .tempTimeout(tempTimeout), .calDone(calDone), .calRaw(calRaw), .rdsonDone(rdsonDone),
        .rdsonOne(rdsonOne), .rdsonTwo(rdsonTwo), .tdcMemReq(tdcMemReq), .aluMemReq(aluMemReq),
        .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
        .chargeEn(chargeEn), .dischEn(dischEn), .dischSel(dischSel), .busy(busy));
    sgr_cmp_model u_cmp (.mclk(mclk), .dischEn(dischEn), .dischSel(dischSel), .stuck(stuck),
        .cmpTrig(cmpTrig));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One read: answer stands the cycle after the taking edge.
    task automatic rd(input logic [2:0] a, output logic [23:0] d);
        @(posedge mclk);
        rdEn <= 1'h1;
        rdAddr <= a;
        @(posedge mclk);
        rdEn <= 1'h0;
        #1;
        chk("rdValid", {23'h0, rdValid}, 24'h1);
        d = rdData;
    endtask : rd
    task automatic meas;
        int i;
        @(posedge mclk);
        measStart <= 1'h1;
        @(posedge mclk);
        measStart <= 1'h0;
        for (i = 0; i < 4000; i++) begin
            @(posedge mclk);
            #1;
            if (busy === 1'h0) break;
        end
        if (i == 4000) begin
            miscompares++;
            complete_run();
        end
    endtask : meas
    // Model difference of one half is four discharges of (1 + half + 2 * bridge) cycles.
    function automatic logic [23:0] hv(input int fb, input int h);
        return 24'(1 + h + 2 * fb) << 10;
    endfunction : hv
    task automatic t_modes;
        logic [23:0] d, e2, prev2;
        logic [1:0] sels [5] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2};
        logic sums [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
        logic difs [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
        logic act, prevAct;
        int fb;
        for (int db = 0; db < 2; db++) begin
            for (int m = 0; m < 5; m++) begin
                @(posedge mclk);
                cfg <= sgr_cfg_s'({db[0], sums[m], difs[m], 3'h0, 22'h0, sels[m]});
                meas();
                rd(ADDR_STAT, d);
                act = d[ST_ACTIVE_BIT];
                if (db == 1 && m == 1) chk("bridge flag", {23'h0, act}, {23'h0, !prevAct});
                prevAct = act;
                fb = db == 0 ? 0 : (sels[m] == 2'h0 ? int'(act) : int'(sels[m]) - 1);
                e2 = sums[m] ? hv(fb, 0) + hv(fb, 1) : (difs[m] ? hv(fb, 1) - hv(fb, 0) : hv(fb, 1));
                if (db == 0 && sels[m] == 2'h1) e2 = prev2;
                rd(ADDR_HB1, d);
                if (db == 0 || sels[m] != 2'h0) chk("first word", d, hv(fb, 0));
                rd(ADDR_HB2, d);
                chk("second word", d, e2);
                prev2 = e2;
            end
        end
        $display("mode test done");
    endtask : t_modes
    task automatic t_status;
        logic [23:0] d;
        @(posedge mclk);
        cfg <= sgr_cfg_s'({6'h00, 24'hA5C3F0});
        {tempDone, calDone, rdsonDone, stuck} <= 4'hF;
        @(posedge mclk);
        {tempDone, calDone, rdsonDone} <= 3'h0;
        meas();
        rd(ADDR_STAT, d);
        // Both halves time out; temperature and both halves are valid, no error.
        chk("stuck status", d, 24'h731234);
        @(posedge mclk);
        {stuck, tempDone, tempTimeout} <= 3'h3;
        @(posedge mclk);
        tempDone <= 1'h0;
        meas();
        rd(ADDR_STAT, d);
        chk("clean status", 24'(d[22:16]), 24'h74);
        rd(ADDR_HB1, d);
        rd(ADDR_STAT, d);
        chk("valid after read", 24'(d[21:20]), 24'h2);
        rd(ADDR_CFG0, d);
        chk("mirror", d, 24'hA5C3F0);
        rd(ADDR_CALIBRATION_PERIOD_WORD, d);
        chk("cal", d, calRaw >> 3);
        rd(ADDR_RD1, d);
        chk("rdson one", d, rdsonOne);
        rd(ADDR_RD2, d);
        chk("rdson two", d, rdsonTwo);
        $display("status test done");
    endtask : t_status
    task automatic t_err;
        logic [23:0] d;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            {tdcMemReq, aluMemReq} <= {1'h1, k[0]};
            @(posedge mclk);
            {tdcMemReq, aluMemReq} <= 2'h0;
            rd(ADDR_STAT, d);
            chk("error flag", 24'(d[ST_ERR_BIT]), 24'(k));
        end
        rd(ADDR_STAT, d);
        chk("error cleared", 24'(d[ST_ERR_BIT]), 24'h0);
        $display("error test done");
    endtask : t_err
    task automatic t_tdc;
        logic [23:0] c, d;
        @(posedge mclk);
        cfg.range1 <= 1'h1;
        meas();
        rd(ADDR_DISCHARGE_TIME_WORD, c);
        // Last discharge is half two, resistor one, which the model trips after 2 cycles.
        chk("raw count", c, 24'h000002);
        @(posedge mclk);
        cfg.range1 <= 1'h0;
        cfg.divExp <= 2'h2;
        meas();
        rd(ADDR_DISCHARGE_TIME_WORD, d);
        chk("time word", d, 24'((40'(c) << 16) >> 2));
        $display("time test done");
    endtask : t_tdc
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        t_modes();
        t_status();
        t_err();
        t_tdc();
        complete_run();
    end
endmodule : tb_strain_result_readout
`default_nettype wire

//--- verilog/sgr_readout.sv
/*
 * Measurement sequencer and result readout of the strain front end.
 * Assumes synchronous inputs on mclk, an outside comparator and an
 * outside temperature, calibration and Rdson unit that deliver strobes.
 */
// Summary of operation
// - Plain mode: selection picks the filled words.
// - Plain mode: second word takes sum or difference.
// - Double mode: selection 1/2 fixes the bridge.
// - Double mode 0/3: active bridge sources second word.
// - Status shows the bridge actually measured.
// - Half results are 16.8 fixed point.
// - Status holds temperature and half validity flags.
// - Memory collision raises the processing error.
// - Separate timeout flags per half and temperature.
// - Read word mirrors configuration word zero.
// - Range 2 time word is 8.16 reference periods.
// - Range 1 time word counts converter steps.
// - Calibration word counts eight-step units.
// - Charge to supply, time discharge to trigger.
// - Alternate both resistors of a halfbridge.
// - Eight discharge cycles per halfbridge.
`timescale 1ns/100ps
`default_nettype none
module sgr_readout
    import sgr_pkg::*;
#(
    parameter int TimeoutCyc = TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sgr_cfg_s cfg,
    input wire logic measStart,
    input wire logic cmpTrig,
    input wire logic tempDone,
    input wire logic [15:0] tempValue,
    input wire logic tempTimeout,
    input wire logic calDone,
    input wire logic [23:0] calRaw,
    input wire logic rdsonDone,
    input wire logic [23:0] rdsonOne,
    input wire logic [23:0] rdsonTwo,
    input wire logic tdcMemReq,
    input wire logic aluMemReq,
    input wire logic rdEn,
    input wire logic [2:0] rdAddr,
    output logic [23:0] rdData,
    output logic rdValid,
    output logic chargeEn,
    output logic dischEn,
    output logic [2:0] dischSel,
    output logic busy
);
    localparam logic [15:0] CHARGE_LAST = 16'(CHARGE_CYC - 1);
    localparam logic [15:0] TIMEOUT_LAST = 16'(TimeoutCyc - 1);

    sgr_regs_s r_reg; // Registered state.
    sgr_regs_s r_next; // Next state.
    logic [1:0] sel; // Bridge selection from configuration word zero.
    logic sel03; // Selection 0 or 3.
    logic [23:0] st; // Assembled status word.

    // Turns two accumulated discharge sums into a 16.8 half result.
    function automatic logic [23:0] toFix(input logic [19:0] a, input logic [19:0] b);
        logic [19:0] d;
        d = a - b;
        return {d[15:0], 8'h00};
    endfunction : toFix

    // Formats one discharge count for the selected measuring range.
    function automatic logic [23:0] tdcWord(input logic [15:0] c, input logic r1,
                                            input logic [1:0] e);
        logic [39:0] w;
        w = {8'h00, c, 16'h0000} >> e;
        if (r1) begin
            return {8'h00, c};
        end
        return w[23:0];
    endfunction : tdcWord

    assign sel = cfg.cfgWord[1:0];
    assign sel03 = (sel == 2'h0) || (sel == 2'h3);

    // Status word is assembled from the live flags.
    always_comb begin
        st = {8'h00, r_reg.tempRes};
        st[ST_ACTIVE_BIT] = r_reg.fb;
        st[ST_TMP_VALID_BIT] = r_reg.vTmp;
        st[ST_HB2_VALID_BIT] = r_reg.vHb2;
        st[ST_HB1_VALID_BIT] = r_reg.vHb1;
        st[ST_ERR_BIT] = r_reg.errDsp;
        st[ST_TO_TMP_BIT] = r_reg.toTmp;
        st[ST_TO_HB2_BIT] = r_reg.toHb2;
        st[ST_TO_HB1_BIT] = r_reg.toHb1;
    end

    // Next-state logic of sequencer, words and flags.
    always_comb begin
        logic both;
        logic [23:0] h0;
        logic [23:0] h1;
        both = 1'b0;
        h0 = r_reg.halfVal[0];
        h1 = r_reg.halfVal[1];
        r_next = r_reg;
        r_next.rdValid = 1'b0;
        unique case (r_reg.st)
            ST_IDLE: begin
                // A start while a cycle runs is ignored.
                if (measStart) begin
                    r_next.st = ST_CHARGE;
                    r_next.cnt = 16'h0000;
                    r_next.cyc = 3'h0;
                    r_next.res = 1'b0;
                    r_next.accA = 20'h00000;
                    r_next.accB = 20'h00000;
                    r_next.tmo = 2'h0;
                    r_next.measured = 2'h0;
                    // Single-half selections only exist outside double mode.
                    r_next.half = !cfg.dblBridge && (sel == 2'h2);
                    r_next.lastHalf = cfg.dblBridge || (sel != 2'h1);
                    if (cfg.dblBridge && !sel03) begin
                        r_next.fb = (sel == 2'h2);
                    end else if (cfg.dblBridge) begin
                        r_next.fb = r_reg.alt;
                        r_next.alt = !r_reg.alt;
                    end else begin
                        r_next.fb = 1'b0;
                    end
                end
            end
            ST_CHARGE: begin
                // Capacitor charges to the supply for a fixed time.
                r_next.cnt = r_reg.cnt + 16'h0001;
                if (r_reg.cnt == CHARGE_LAST) begin
                    r_next.st = ST_DISCH;
                    r_next.cnt = 16'h0000;
                end
            end
            ST_DISCH: begin
                r_next.cnt = r_reg.cnt + 16'h0001;
                // Discharge ends at the comparator level or at the timeout.
                if (cmpTrig || (r_reg.cnt == TIMEOUT_LAST)) begin
                    if (!cmpTrig) begin
                        r_next.tmo[r_reg.half] = 1'b1;
                    end
                    if (r_reg.res) begin
                        r_next.accB = r_reg.accB + {4'h0, r_reg.cnt};
                    end else begin
                        r_next.accA = r_reg.accA + {4'h0, r_reg.cnt};
                    end
                    r_next.discharge_time_word = tdcWord(r_reg.cnt, cfg.range1, cfg.divExp);
                    r_next.res = !r_reg.res;
                    r_next.cyc = r_reg.cyc + 3'h1;
                    r_next.cnt = 16'h0000;
                    r_next.st = ST_CHARGE;
                    if (r_reg.cyc == LAST_CYCLE) begin
                        r_next.halfVal[r_reg.half] = toFix(r_next.accA, r_next.accB);
                        r_next.measured[r_reg.half] = 1'b1;
                        r_next.accA = 20'h00000;
                        r_next.accB = 20'h00000;
                        if (r_reg.half == r_reg.lastHalf) begin
                            r_next.st = ST_DONE;
                        end else begin
                            r_next.half = 1'b1;
                        end
                    end
                end
            end
            ST_DONE: begin
                r_next.st = ST_IDLE;
                r_next.toHb1 = r_reg.measured[0] ? r_reg.tmo[0] : r_reg.toHb1;
                r_next.toHb2 = r_reg.measured[1] ? r_reg.tmo[1] : r_reg.toHb2;
                if (cfg.dblBridge) begin
                    // Selection 1 or 2 always yields both halves of one bridge.
                    both = !sel03 || (!cfg.sumOpt && !cfg.diffOpt && !r_reg.fb);
                end else begin
                    both = sel03 && !cfg.sumOpt && !cfg.diffOpt;
                end
                if (both || (!cfg.dblBridge && sel == 2'h1)) begin
                    r_next.hb1 = h0;
                    r_next.vHb1 = 1'b1;
                end
                if (!(!cfg.dblBridge && sel == 2'h1)) begin
                    r_next.vHb2 = 1'b1;
                    if (!sel03 || both) begin
                        r_next.hb2 = h1;
                    end else if (cfg.sumOpt) begin
                        r_next.hb2 = h0 + h1;
                    end else if (cfg.diffOpt) begin
                        r_next.hb2 = h1 - h0;
                    end else begin
                        r_next.hb2 = h1;
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        // Reads clear the half validity and error flags; a same-cycle set wins below.
        if (rdEn) begin
            r_next.rdValid = 1'b1;
            unique case (rdAddr)
                ADDR_HB1: begin
                    r_next.rdData = r_reg.hb1;
                    r_next.vHb1 = 1'b0;
                end
                ADDR_HB2: begin
                    r_next.rdData = r_reg.hb2;
                    r_next.vHb2 = 1'b0;
                end
                ADDR_STAT: begin
                    r_next.rdData = st;
                    r_next.errDsp = 1'b0;
                end
                ADDR_CFG0: begin
                    r_next.rdData = cfg.cfgWord;
                end
                ADDR_DISCHARGE_TIME_WORD: begin
                    r_next.rdData = r_reg.discharge_time_word;
                end
                ADDR_CALIBRATION_PERIOD_WORD: begin
                    r_next.rdData = r_reg.calibration_period_word;
                end
                ADDR_RD1: begin
                    r_next.rdData = r_reg.rd1;
                end
                ADDR_RD2: begin
                    r_next.rdData = r_reg.rd2;
                end
            endcase
            // Result words re-validated in the same cycle stay valid.
            if (r_reg.st == ST_DONE) begin
                r_next.vHb1 = r_next.vHb1 | (r_reg.vHb1 & (rdAddr != ADDR_HB1));
            end
        end
        if (r_reg.st == ST_DONE) begin
            if (both || (!cfg.dblBridge && sel == 2'h1)) begin
                r_next.vHb1 = 1'b1;
            end
            if (!(!cfg.dblBridge && sel == 2'h1)) begin
                r_next.vHb2 = 1'b1;
            end
        end
        if (tdcMemReq && aluMemReq) begin
            r_next.errDsp = 1'b1;
        end
        // Temperature comes from the outside unit as a finished value.
        if (tempDone) begin
            r_next.tempRes = tempValue;
            r_next.vTmp = 1'b1;
            r_next.toTmp = tempTimeout;
        end
        if (calDone) begin
            r_next.calibration_period_word = calRaw >> CAL_STEP_SHIFT;
        end
        if (rdsonDone) begin
            r_next.rd1 = rdsonOne;
            r_next.rd2 = rdsonTwo;
        end
    end

    // State register; every field resets to a constant.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state flops.
    assign rdData = r_reg.rdData;
    assign rdValid = r_reg.rdValid;
    assign chargeEn = (r_reg.st == ST_CHARGE);
    assign dischEn = (r_reg.st == ST_DISCH);
    assign dischSel = {r_reg.fb, r_reg.half, r_reg.res};
    assign busy = (r_reg.st != ST_IDLE);
endmodule : sgr_readout
`default_nettype wire
